// [core/rcd_receive_clock_select.sv]
// receive clock source/rate selection and signal detector threshold decode, per channel
`timescale 1ns/1ps
`include "rcd_consts.svh"

module rcd_receive_clock_select
  import rcd_pkg::*;
#(
  parameter int NUM_CHANNELS = 4
)(
  // system clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`RCD_ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // link side, sampling clock and per-channel clock pins
  input  wire logic                       linkClock,
  input  wire logic [NUM_CHANNELS-1:0]    channelReferenceClock,
  input  wire logic [NUM_CHANNELS-1:0]    recoveredByteClock,
  output logic      [NUM_CHANNELS-1:0]    rxOutputClockTrue,
  output logic      [NUM_CHANNELS-1:0]    rxOutputClockComp,
  output logic      [NUM_CHANNELS-1:0]    outputRegisterLoad,
  // decoded signal detector settings
  output rcd_detect_t [NUM_CHANNELS-1:0]  primaryDetect,
  output rcd_detect_t [NUM_CHANNELS-1:0]  secondaryDetect
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_CHANNELS < 1 || NUM_CHANNELS > `RCD_MAX_CHANNELS)
  begin : gBadChannels
    $error("NUM_CHANNELS must be between 1 and the register map size");
  end

  if (`RCD_STAT_W * NUM_CHANNELS > 32)
  begin : gBadStatus
    $error("status word cannot hold every channel");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic rcd_detect_t decodeThreshold(input logic [1:0] code);
    rcd_detect_t d;
    d.enable      = (code != `RCD_THR_OFF);
    case (code)
      `RCD_THR_LOW:  d.thresholdMv = `RCD_MV_LOW;
      `RCD_THR_MID:  d.thresholdMv = `RCD_MV_MID;
      `RCD_THR_HIGH: d.thresholdMv = `RCD_MV_HIGH;
      default:       d.thresholdMv = `RCD_MV_NONE;
    endcase
    return d;
  endfunction : decodeThreshold

  function automatic rcd_chan_cfg_t resetConfig();
    rcd_chan_cfg_t c;
    c.rxClockSourceSelect      = `RCD_RST_SRC;
    c.rxClockRateSelect        = `RCD_RST_RATE;
    c.primaryDetectThreshold   = `RCD_RST_THRESH;
    c.secondaryDetectThreshold = `RCD_RST_THRESH;
    c.refHalfRate              = `RCD_RST_REFHALF;
    return c;
  endfunction : resetConfig

  function automatic rcd_chan_cfg_t unpackConfig(input logic [31:0] w);
    rcd_chan_cfg_t c;
    c.rxClockSourceSelect      = w[`RCD_CFG_SRC_BIT];
    c.rxClockRateSelect        = w[`RCD_CFG_RATE_BIT];
    c.primaryDetectThreshold   = w[`RCD_CFG_PRI_LSB +: 2];
    c.secondaryDetectThreshold = w[`RCD_CFG_SEC_LSB +: 2];
    c.refHalfRate              = w[`RCD_CFG_REFHALF_BIT];
    return c;
  endfunction : unpackConfig

  function automatic logic [31:0] packConfig(input rcd_chan_cfg_t c);
    logic [31:0] w;
    w                            = 32'h0000_0000;
    w[`RCD_CFG_SRC_BIT]          = c.rxClockSourceSelect;
    w[`RCD_CFG_RATE_BIT]         = c.rxClockRateSelect;
    w[`RCD_CFG_PRI_LSB +: 2]     = c.primaryDetectThreshold;
    w[`RCD_CFG_SEC_LSB +: 2]     = c.secondaryDetectThreshold;
    w[`RCD_CFG_REFHALF_BIT]      = c.refHalfRate;
    return w;
  endfunction : packConfig

  // a half-rate reference already carries one character per edge
  function automatic logic halfRateReference(input rcd_chan_cfg_t c);
    return c.rxClockSourceSelect & c.refHalfRate;
  endfunction : halfRateReference

  // ----------------------------------------------------------------
  // system clock domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    rcd_chan_cfg_t [NUM_CHANNELS-1:0] cfg;
    rcd_detect_t   [NUM_CHANNELS-1:0] pri;
    rcd_detect_t   [NUM_CHANNELS-1:0] sec;
    logic [NUM_CHANNELS-1:0][`RCD_STAT_W-1:0] statSync1;
    logic [NUM_CHANNELS-1:0][`RCD_STAT_W-1:0] statSync2;
    rcd_chan_cfg_t [NUM_CHANNELS-1:0] shadow;
    logic                             reqToggle;
    logic                             ackSync1;
    logic                             ackSync2;
    logic [31:0]                      rdata;
    logic                             ready;
    logic                             slverr;
  } rcd_sys_state_t;

  rcd_sys_state_t sys_reg;
  rcd_sys_state_t sys_next;

  // ----------------------------------------------------------------
  // link clock domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                        rstSync;
    logic [1:0]                        reqSync;
    logic                              reqSeen;
    rcd_link_chan_t [NUM_CHANNELS-1:0] ch;
  } rcd_link_state_t;

  rcd_link_state_t link_reg;
  rcd_link_state_t link_next;

  // ----------------------------------------------------------------
  // apb register file and detector decode
  // ----------------------------------------------------------------
  logic [`RCD_ADDR_W-1:0] cfgIndex;
  logic                   setupPhase;
  logic                   accessDone;
  logic                   isCfg;
  logic                   isStatus;

  assign cfgIndex   = (paddr - `RCD_OFF_CFG0) >> 2;
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & sys_reg.ready;
  assign isCfg      = (paddr[1:0] == 2'h0) && (paddr >= `RCD_OFF_CFG0)
                      && (cfgIndex < `RCD_ADDR_W'(NUM_CHANNELS));
  assign isStatus   = (paddr == `RCD_OFF_STATUS);

  always_comb
  begin
    sys_next        = sys_reg;
    // answer comes in the first access cycle: one wait-free transfer
    sys_next.ready  = setupPhase;
    if (setupPhase)
    begin
      sys_next.rdata  = 32'h0000_0000;
      sys_next.slverr = 1'b0;
      if (isCfg)
      begin
        sys_next.rdata = packConfig(sys_reg.cfg[cfgIndex[1:0]]);
      end
      else if (isStatus && !pwrite)
      begin
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
          sys_next.rdata[i*`RCD_STAT_W +: `RCD_STAT_W] = sys_reg.statSync2[i];
        end
      end
      else
      begin
        // unmapped address, or a write to the read-only status word
        sys_next.slverr = 1'b1;
      end
    end
    if (accessDone && pwrite && isCfg)
    begin
      sys_next.cfg[cfgIndex[1:0]] = unpackConfig(pwdata);
    end
    for (int i = 0; i < NUM_CHANNELS; i++)
    begin
      sys_next.pri[i] = decodeThreshold(sys_reg.cfg[i].primaryDetectThreshold);
      sys_next.sec[i] = decodeThreshold(sys_reg.cfg[i].secondaryDetectThreshold);
      // link status comes back as quasi-static levels
      sys_next.statSync1[i] = {link_reg.ch[i].halfActive,
                               link_reg.ch[i].cfgSync2.rxClockSourceSelect};
      sys_next.statSync2[i] = sys_reg.statSync1[i];
    end
    // settings cross as one word under a toggle handshake, so the link side
    // never applies a half-updated mix of old and new bits
    sys_next.ackSync1 = link_reg.reqSeen;
    sys_next.ackSync2 = sys_reg.ackSync1;
    if ((sys_reg.reqToggle == sys_reg.ackSync2) && (sys_reg.shadow != sys_reg.cfg))
    begin
      sys_next.shadow    = sys_reg.cfg;
      sys_next.reqToggle = ~sys_reg.reqToggle;
    end
    if (rst)
    begin
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
        sys_next.cfg[i]       = resetConfig();
        sys_next.pri[i]       = decodeThreshold(`RCD_RST_THRESH);
        sys_next.sec[i]       = decodeThreshold(`RCD_RST_THRESH);
        sys_next.statSync1[i] = '0;
        sys_next.statSync2[i] = '0;
        sys_next.shadow[i]    = resetConfig();
      end
      sys_next.reqToggle = 1'b0;
      sys_next.ackSync1  = 1'b0;
      sys_next.ackSync2  = 1'b0;
      sys_next.rdata  = 32'h0000_0000;
      sys_next.ready  = 1'b0;
      sys_next.slverr = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    sys_reg <= sys_next;
  end

  assign prdata          = sys_reg.rdata;
  assign pready          = sys_reg.ready;
  assign pslverr         = sys_reg.slverr;
  assign primaryDetect   = sys_reg.pri;
  assign secondaryDetect = sys_reg.sec;

  // ----------------------------------------------------------------
  // link side clock selection
  // ----------------------------------------------------------------
  // channel clocks are sampled on linkClock, so each must run below half
  // its rate; output edges lag the source by three linkClock cycles
  // a settings change lands some two clocks plus four linkClock cycles
  // after the write; faster writes merge and the last one wins
  always_comb
  begin
    logic srcLevel;
    logic rise;
    logic fall;
    logic toggleMode;
    logic nextTrue;
    logic capture;
    rcd_chan_cfg_t c;
    srcLevel   = 1'b0;
    rise       = 1'b0;
    fall       = 1'b0;
    toggleMode = 1'b0;
    nextTrue   = 1'b0;
    capture    = 1'b0;
    c          = resetConfig();
    link_next  = link_reg;
    // reset crosses as a level; it runs freely so it can release itself
    link_next.rstSync = {link_reg.rstSync[0], rst};
    link_next.reqSync = {link_reg.reqSync[0], sys_reg.reqToggle};
    capture           = link_reg.reqSync[1] ^ link_reg.reqSeen;
    link_next.reqSeen = link_reg.reqSync[1];
    for (int i = 0; i < NUM_CHANNELS; i++)
    begin
      link_next.ch[i].refSync  = {link_reg.ch[i].refSync[0], channelReferenceClock[i]};
      link_next.ch[i].recSync  = {link_reg.ch[i].recSync[0], recoveredByteClock[i]};
      // the shadow word holds still while a request is open
      if (capture)
      begin
        link_next.ch[i].cfgSync1 = sys_reg.shadow[i];
      end
      link_next.ch[i].cfgSync2 = link_reg.ch[i].cfgSync1;
      c = link_reg.ch[i].cfgSync2;
      if (c.rxClockSourceSelect)
      begin
        srcLevel = link_reg.ch[i].refSync[1];
      end
      else
      begin
        srcLevel = link_reg.ch[i].recSync[1];
      end
      rise = srcLevel & ~link_reg.ch[i].srcPrev;
      fall = ~srcLevel & link_reg.ch[i].srcPrev;
      // a half-rate reference is already at half rate: rate select ignored
      toggleMode = c.rxClockRateSelect & ~halfRateReference(c);
      if (toggleMode)
      begin
        nextTrue = rise ? ~link_reg.ch[i].clkTrue : link_reg.ch[i].clkTrue;
      end
      else
      begin
        nextTrue = srcLevel;
      end
      link_next.ch[i].srcPrev    = srcLevel;
      link_next.ch[i].clkTrue    = nextTrue;
      link_next.ch[i].clkComp    = ~nextTrue;
      link_next.ch[i].halfActive = toggleMode | halfRateReference(c);
      // a half-rate reference carries one character per edge
      link_next.ch[i].outputLoad = rise | (halfRateReference(c) & fall);
      if (link_reg.rstSync[1])
      begin
        link_next.ch[i].srcPrev    = 1'b0;
        link_next.ch[i].cfgSync1   = resetConfig();
        link_next.ch[i].cfgSync2   = resetConfig();
        link_next.ch[i].clkTrue    = 1'b0;
        link_next.ch[i].clkComp    = 1'b1;
        link_next.ch[i].outputLoad = 1'b0;
        link_next.ch[i].halfActive = 1'b1;
      end
    end
    if (link_reg.rstSync[1])
    begin
      link_next.reqSeen = 1'b0;
    end
  end

  always_ff @(posedge linkClock)
  begin
    link_reg <= link_next;
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CHANNELS; i++)
    begin
      rxOutputClockTrue[i]  = link_reg.ch[i].clkTrue;
      rxOutputClockComp[i]  = link_reg.ch[i].clkComp;
      outputRegisterLoad[i] = link_reg.ch[i].outputLoad;
    end
  end

endmodule : rcd_receive_clock_select

// [core/rcd_consts.svh]
// constants for the receive clock and detect select block
`ifndef RCD_CONSTS_SVH
`define RCD_CONSTS_SVH

// register byte offsets, address width and channel limit
`define RCD_OFF_CFG0        8'h00
`define RCD_OFF_STATUS      8'h10
`define RCD_ADDR_W          8
`define RCD_MAX_CHANNELS    4

// per-channel configuration word layout
`define RCD_CFG_SRC_BIT     0
`define RCD_CFG_RATE_BIT    1
`define RCD_CFG_PRI_LSB     2
`define RCD_CFG_SEC_LSB     4
`define RCD_CFG_REFHALF_BIT 6
`define RCD_CFG_W           7

// initialization values
`define RCD_RST_SRC         1'h1
`define RCD_RST_RATE        1'h1
`define RCD_RST_THRESH      2'h2
`define RCD_RST_REFHALF     1'h0

// detector threshold field codes
`define RCD_THR_OFF         2'h0
`define RCD_THR_LOW         2'h1
`define RCD_THR_MID         2'h2
`define RCD_THR_HIGH        2'h3

// typical thresholds in mV peak-to-peak
`define RCD_MV_LOW          10'h08C
`define RCD_MV_MID          10'h118
`define RCD_MV_HIGH         10'h1A4
`define RCD_MV_NONE         10'h000

// status word: two bits per channel
`define RCD_STAT_W          2

`endif

// [core/rcd_pkg.sv]
// types for the receive clock and detect select block
package rcd_pkg;

  // one channel's software settings
  typedef struct packed {
    logic       refHalfRate;
    logic [1:0] secondaryDetectThreshold;
    logic [1:0] primaryDetectThreshold;
    logic       rxClockRateSelect;
    logic       rxClockSourceSelect;
  } rcd_chan_cfg_t;

  // one decoded signal detector setting
  typedef struct packed {
    logic       enable;
    logic [9:0] thresholdMv;
  } rcd_detect_t;

  // link-side state of one channel
  typedef struct packed {
    logic [1:0]    refSync;
    logic [1:0]    recSync;
    logic          srcPrev;
    rcd_chan_cfg_t cfgSync1;
    rcd_chan_cfg_t cfgSync2;
    logic          clkTrue;
    logic          clkComp;
    logic          outputLoad;
    logic          halfActive;
  } rcd_link_chan_t;

endpackage : rcd_pkg

// [dv/rcd_host_model.sv]
// host model that latches one channel's receive characters
`timescale 1ns/1ps
module rcd_host_model (
  // clock pair, load pulse and capture mode
  input  wire logic linkClock,
  input  wire logic clkTrue,
  input  wire logic clkComp,
  input  wire logic load,
  input  wire logic halfMode,
  // running counts
  output int        captures,
  output int        loads
);
  int c = 0;
  int l = 0;
  assign captures = c;
  assign loads = l;
  // complement rising edges only carry a character in half-rate modes
  always @(posedge clkTrue or posedge clkComp)
    if (clkTrue || halfMode)
      c <= c + 1;
  always @(posedge linkClock)
    if (load === 1'b1)
      l <= l + 1;
endmodule : rcd_host_model

// [dv/rcd_receive_clock_select_chk.sv]
// assertions on the receive clock select ports
`timescale 1ns/1ps
module rcd_chk
  import rcd_pkg::*;
#(
  parameter int NUM_CHANNELS = 4
)(
  // system side
  input wire logic                      clock,
  input wire logic                      rst,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire rcd_detect_t [NUM_CHANNELS-1:0] primaryDetect,
  input wire rcd_detect_t [NUM_CHANNELS-1:0] secondaryDetect,
  // link side
  input wire logic                      linkClock,
  input wire logic [NUM_CHANNELS-1:0]   rxOutputClockTrue,
  input wire logic [NUM_CHANNELS-1:0]   rxOutputClockComp,
  input wire logic [NUM_CHANNELS-1:0]   outputRegisterLoad
);
  property p_rdy;
    @(posedge clock) disable iff (rst) psel && !penable |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not a single pulse");
  property p_err;
    @(posedge clock) disable iff (rst) pready && (paddr[1:0] != 2'h0
      || (paddr[7:2] >= NUM_CHANNELS && !(paddr == 8'h10 && !pwrite))) |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("bad access not refused");
  property p_prst;
    @(posedge clock) rst |=> primaryDetect[0] == {1'b1, 10'h118};
  endproperty
  a_prst: assert property (p_prst) else $error("primary detect reset");
  property p_srst;
    @(posedge clock) rst |=> secondaryDetect[0] == {1'b1, 10'h118};
  endproperty
  a_srst: assert property (p_srst) else $error("secondary detect reset");
  property p_pdec;
    @(posedge clock) disable iff (rst) primaryDetect[0].enable
      ? primaryDetect[0].thresholdMv inside {10'h08C, 10'h118, 10'h1A4}
      : primaryDetect[0].thresholdMv == 10'h000;
  endproperty
  a_pdec: assert property (p_pdec) else $error("primary decode");
  property p_sdec;
    @(posedge clock) disable iff (rst) secondaryDetect[0].enable
      ? secondaryDetect[0].thresholdMv inside {10'h08C, 10'h118, 10'h1A4}
      : secondaryDetect[0].thresholdMv == 10'h000;
  endproperty
  a_sdec: assert property (p_sdec) else $error("secondary decode");
  property p_iso;
    @(posedge clock) disable iff (rst)
      pready && pwrite && paddr == 8'h04 |=> ##1 $stable(primaryDetect[0]);
  endproperty
  a_iso: assert property (p_iso) else $error("channel 1 write moved channel 0");
  property p_pair;
    @(posedge linkClock) disable iff (rst) rxOutputClockComp[0] == !rxOutputClockTrue[0];
  endproperty
  a_pair: assert property (p_pair) else $error("clock pair not complementary");
  property p_load;
    @(posedge linkClock) disable iff (rst)
      outputRegisterLoad[0] |-> $changed(rxOutputClockTrue[0]) ##1 !outputRegisterLoad[0];
  endproperty
  a_load: assert property (p_load) else $error("load without clock edge");
endmodule : rcd_chk

bind rcd_receive_clock_select rcd_chk #(.NUM_CHANNELS(NUM_CHANNELS)) i_chk (
  .clock, .rst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .primaryDetect, .secondaryDetect, .linkClock, .rxOutputClockTrue,
  .rxOutputClockComp, .outputRegisterLoad);

// [dv/tb.sv]
// testbench for the receive clock and detect select block
`timescale 1ns/1ps
module tb
  import rcd_pkg::*;
;
  logic              clock = 0, rst = 1, linkClock = 0, halfMode = 0;
  logic              psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata, rd;
  logic [3:0]        refC = 4'h0, recC = 4'h0, outT, outC, outL;
  rcd_detect_t [3:0] priD, secD;
  logic [9:0]        mv [4] = '{10'h000, 10'h08C, 10'h118, 10'h1A4};
  int                caps, lds, n_mismatch = 0, cmp_count = 0, cyc = 0;

  initial forever #10 clock = ~clock;
  initial
  begin
    #3;
    forever #6 linkClock = ~linkClock;
  end

  rcd_receive_clock_select #(.NUM_CHANNELS(4)) i_dut (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .linkClock, .channelReferenceClock(refC), .recoveredByteClock(recC),
    .rxOutputClockTrue(outT), .rxOutputClockComp(outC), .outputRegisterLoad(outL),
    .primaryDetect(priD), .secondaryDetect(secD));
  rcd_host_model i_host (.linkClock, .clkTrue(outT[0]), .clkComp(outC[0]),
    .load(outL[0]), .halfMode, .captures(caps), .loads(lds));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // idle edge first so release and next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // selected source gives 4 pulses, the other 8, so a wrong pick shows up
  task automatic pulses(input logic src);
    for (int i = 0; i < 16; i++)
    begin
      repeat (3) @(posedge clock);
      if (!src || i[0]) refC <= ~refC;
      if (src || i[0]) recC <= ~recC;
    end
  endtask : pulses

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0000002B);
      chk(32'(priD[i]), 32'({1'b1, 10'h118}));
      chk(32'(secD[i]), 32'({1'b1, 10'h118}));
    end
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h000000FF);
    apb(1'b0, 8'h22, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, 8'h10, 32'h1);
    chk(32'(er), 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_detect;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 8'h00, 32'(3 | (k << 2) | ((3 - k) << 4)));
      repeat (3) @(posedge clock);
      chk(32'(priD[0]), 32'({k != 0, mv[k]}));
      chk(32'(secD[0]), 32'({k != 3, mv[3 - k]}));
      chk(32'(priD[1]), 32'({1'b1, 10'h118}));
    end
    apb(1'b1, 8'h04, 32'h00000013);
    repeat (3) @(posedge clock);
    chk(32'(priD[1]), 32'({1'b0, 10'h000}));
    chk(32'(secD[1]), 32'({1'b1, 10'h08C}));
    chk(32'(priD[0]), 32'({1'b1, 10'h1A4}));
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h00000013);
    $display("test detect done");
  endtask : t_detect

  task automatic t_clock;
    logic [2:0] m [6] = '{3'b010, 3'b000, 3'b011, 3'b001, 3'b101, 3'b111};
    int c0, l0, e;
    for (int j = 0; j < 6; j++)
    begin
      apb(1'b1, 8'h00, {25'h0, m[j][2], 4'hA, m[j][1:0]});
      halfMode <= m[j][1] | (m[j][0] & m[j][2]);
      repeat (20) @(posedge clock);
      c0 = caps;
      l0 = lds;
      e = (m[j][0] & m[j][2]) ? 8 : 4;
      pulses(m[j][0]);
      repeat (20) @(posedge clock);
      chk(32'(caps - c0), 32'(e));
      chk(32'(lds - l0), 32'(e));
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, {24'h0, 6'h3F, halfMode, m[j][0]});
    end
    $display("test clock done");
  endtask : t_clock

  // ----------------------------------------
  // main sequence and hang limit
  // ----------------------------------------
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_reset();
    t_detect();
    t_clock();
    end_sim();
  end
endmodule : tb
